//--- rxbsm_consts.vh
// constants for the receive buffer status manager
// assumes an 8 kbyte buffer memory addressed by 13-bit pointers
`ifndef RXBSM_CONSTS_VH
`define RXBSM_CONSTS_VH
// register byte addresses on the axi4-lite slave
`define RXBSM_ADDR_CTRL2       8'h00
`define RXBSM_ADDR_RELPTR_LO   8'h04
`define RXBSM_ADDR_RELPTR_HI   8'h08
`define RXBSM_ADDR_RXSTART     8'h0C
`define RXBSM_ADDR_RXEND       8'h10
`define RXBSM_ADDR_RDPTR       8'h14
`define RXBSM_ADDR_WRPTR       8'h18
`define RXBSM_ADDR_PKTCNT      8'h1C
`define RXBSM_ADDR_FLAGS       8'h20
`define RXBSM_ADDR_RDDATA      8'h24
// control two fields
`define RXBSM_BIT_READ_AUTO_INCREMENT_ENABLE      7
`define RXBSM_BIT_PENDING_COUNT_DECREMENT       6
// flag fields
`define RXBSM_BIT_PKTPEND      6
`define RXBSM_BIT_RXERR        0
// status vector fields
`define RXBSM_SV_VLAN          30
`define RXBSM_SV_UNKOP         29
`define RXBSM_SV_PAUSE         28
`define RXBSM_SV_CTRL          27
`define RXBSM_SV_DRIBBLE       26
`define RXBSM_SV_BCAST         25
`define RXBSM_SV_MCAST         24
`define RXBSM_SV_OK            23
`define RXBSM_SV_LENRANGE      22
`define RXBSM_SV_LENCHK        21
`define RXBSM_SV_CRCERR        20
`define RXBSM_SV_CARRIER       18
`define RXBSM_SV_LONGDROP      16
// reset values and limits
`define RXBSM_RST_RXSTART      13'h0000
`define RXBSM_RST_RXEND        13'h1FFF
`define RXBSM_RST_CTRL2        8'h80
`define RXBSM_CNT_MAX          8'hFF
`define RXBSM_TYPE_LIMIT       16'h05DC
`define RXBSM_HDR_BYTES        3'h6
`endif

//--- rxbsm_top.v
// receive buffer status manager: pointers, status vector, pending count,
// buffer memory and an axi4-lite register slave.
// assumes the mac side hands in frame bytes on the same clock with a
// start pulse, byte strobe, an end pulse and per-frame event flags.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "rxbsm_consts.vh"

// Behaviour
// - status bit 30 set for a vlan tagged frame
// - status bit 29 set for control frame with unknown opcode
// - status bit 28 set for valid pause frame with valid address
// - status bit 27 set when type/length marks a control frame
// - extra 1 to 7 trailing bits dropped, status bit 26 set
// - bit 25 for broadcast, bit 24 for multicast destination
// - bit 23 only for good crc and no symbol errors
// - bit 22 when type/length exceeds 1500
// - bit 21 when a valid length field mismatches received data length
// - bit 20 when received crc differs from computed crc
// - bit 18 when carrier activity without receive since last frame
// - bit 16 on long event or dropped packet since last frame
// - bits 15..0 hold frame length, stored low byte first
// - auto-increment read pointer wraps from buffer end to start
// - writes stop just before the release pointer location
// - hitting the release pointer aborts the packet, sets error flag
// - low byte write goes to a latch, high byte write commits both
// - pointer bytes read live values, latch is never readable
// - decrement lowers count by one, clears pending flag at zero
// - decrement at zero count is ignored
// - count at 255 aborts every new packet and sets error flag
// - completed packet bumps count, sets pending, advances write pointer
// - six byte header of next pointer and status vector precedes packet
// - odd end gets one pad byte so packets start even
module rxbsm_top (
  input  wire        clock,
  input  wire        reset,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  input  wire        mac_start,
  input  wire        mac_byte_valid,
  input  wire [7:0]  mac_byte,
  input  wire        mac_end,
  input  wire [2:0]  mac_extra_bits,
  input  wire        mac_vlan,
  input  wire        mac_ctrl_frame,
  input  wire        mac_pause_ok,
  input  wire        mac_unknown_op,
  input  wire        mac_bcast,
  input  wire        mac_mcast,
  input  wire        mac_crc_bad,
  input  wire        mac_symbol_err,
  input  wire [15:0] mac_type_len,
  input  wire        mac_carrier_evt,
  input  wire        mac_long_evt,
  input  wire        mac_drop_evt,
  output reg         rx_busy,
  output reg         rx_error_flag,
  output reg         packet_pending_flag
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_DATA = 4'b0010;
  localparam ST_HDR  = 4'b0100;
  localparam ST_SKIP = 4'b1000;
  localparam [7:0] CTRL2_RST = `RXBSM_RST_CTRL2;

  reg [7:0]  mem [0:8191];
  reg [3:0]  state_reg;
  reg [12:0] rx_buffer_start_reg;
  reg [12:0] rx_buffer_end_reg;
  reg [12:0] rx_release_pointer_reg;
  reg [7:0]  rx_release_low_hold_reg;
  reg [12:0] buffer_read_pointer_reg;
  reg [12:0] rx_hw_write_pointer_reg;
  reg [12:0] wr_addr_reg;
  reg [12:0] hdr_addr_reg;
  reg [15:0] byte_count_reg;
  reg [7:0]  pending_packet_count_reg;
  reg        read_auto_increment_enable_reg;
  reg        carrier_seen_reg;
  reg        longdrop_seen_reg;
  reg [47:0] header_reg;
  reg [2:0]  hdr_idx_reg;
  reg        aw_hold_reg;
  reg        w_hold_reg;
  reg [7:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;

  // address after a given one inside the circular buffer
  function [12:0] wrap_inc;
    input [12:0] a;
    input [12:0] st;
    input [12:0] nd;
    begin
      if (a == nd) begin
        wrap_inc = st;
      end else begin
        wrap_inc = a + 13'h0001;
      end
    end
  endfunction

  wire [12:0] wr_next    = wrap_inc(wr_addr_reg, rx_buffer_start_reg, rx_buffer_end_reg);
  wire [12:0] hdr_next   = wrap_inc(hdr_addr_reg, rx_buffer_start_reg, rx_buffer_end_reg);
  wire [12:0] rd_next    = wrap_inc(buffer_read_pointer_reg, rx_buffer_start_reg,
                                    rx_buffer_end_reg);
  // never write onto the release pointer
  wire        wr_blocked = (wr_addr_reg == rx_release_pointer_reg);
  // next packet always starts on an even address
  wire [12:0] next_pkt   = (wr_addr_reg[0]) ? wr_next : wr_addr_reg;

  // a write commits once, when both halves are held; bvalid follows
  wire        wr_go   = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  wire [7:0]  wa      = aw_addr_reg;
  wire [31:0] wd      = w_data_reg;
  wire [3:0]  ws      = w_strb_reg;
  wire        wr_lane = ws[0];
  wire        dec_req = wr_go && wr_lane && (wa == `RXBSM_ADDR_CTRL2)
                        && wd[`RXBSM_BIT_PENDING_COUNT_DECREMENT];
  wire        rd_go   = s_axi_arvalid && s_axi_arready;
  wire        rd_data = rd_go && (s_axi_araddr == `RXBSM_ADDR_RDDATA);

  // status vector built at end of frame
  wire [31:0] status_vec;
  assign status_vec[31]    = 1'b0;
  assign status_vec[30]    = mac_vlan;
  assign status_vec[29]    = mac_ctrl_frame & mac_unknown_op;
  assign status_vec[28]    = mac_ctrl_frame & mac_pause_ok;
  assign status_vec[27]    = mac_ctrl_frame;
  assign status_vec[26]    = (mac_extra_bits != 3'h0);
  assign status_vec[25]    = mac_bcast;
  assign status_vec[24]    = mac_mcast;
  assign status_vec[23]    = !mac_crc_bad && !mac_symbol_err;
  assign status_vec[22]    = (mac_type_len > `RXBSM_TYPE_LIMIT);
  assign status_vec[21]    = (mac_type_len <= `RXBSM_TYPE_LIMIT)
                             && (mac_type_len != byte_count_reg - 16'h0012);
  assign status_vec[20]    = mac_crc_bad;
  assign status_vec[19]    = 1'b0;
  assign status_vec[18]    = carrier_seen_reg | mac_carrier_evt;
  assign status_vec[17]    = 1'b0;
  assign status_vec[16]    = longdrop_seen_reg | mac_long_evt;
  assign status_vec[15:0]  = byte_count_reg;

  // receive path
  always @(posedge clock) begin
    if (reset) begin
      state_reg               <= ST_IDLE;
      wr_addr_reg             <= `RXBSM_RST_RXSTART;
      hdr_addr_reg            <= `RXBSM_RST_RXSTART;
      rx_hw_write_pointer_reg <= `RXBSM_RST_RXSTART;
      byte_count_reg          <= 16'h0000;
      header_reg              <= 48'h0;
      hdr_idx_reg             <= 3'h0;
      carrier_seen_reg        <= 1'b0;
      longdrop_seen_reg       <= 1'b0;
      pending_packet_count_reg <= 8'h00;
      packet_pending_flag     <= 1'b0;
      rx_error_flag           <= 1'b0;
      rx_busy                 <= 1'b0;
    end else begin
      if (mac_carrier_evt) begin
        carrier_seen_reg <= 1'b1;
      end
      if (mac_long_evt || mac_drop_evt) begin
        longdrop_seen_reg <= 1'b1;
      end
      rx_busy <= (state_reg != ST_IDLE);
      case (state_reg)
        ST_IDLE: begin
          if (mac_start) begin
            if (pending_packet_count_reg == `RXBSM_CNT_MAX) begin
              rx_error_flag     <= 1'b1;
              longdrop_seen_reg <= 1'b1;
              state_reg         <= ST_SKIP;
            end else begin
              // reserve the six header bytes ahead of the data
              hdr_addr_reg   <= rx_hw_write_pointer_reg;
              wr_addr_reg    <= rx_hw_write_pointer_reg + 13'h0006;
              if (rx_hw_write_pointer_reg + 13'h0006 > rx_buffer_end_reg) begin
                wr_addr_reg <= rx_hw_write_pointer_reg + 13'h0006
                               - (rx_buffer_end_reg - rx_buffer_start_reg + 13'h0001);
              end
              byte_count_reg <= 16'h0000;
              state_reg      <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (mac_byte_valid) begin
            if (wr_blocked) begin
              rx_error_flag     <= 1'b1;
              longdrop_seen_reg <= 1'b1;
              state_reg         <= mac_end ? ST_IDLE : ST_SKIP;
            end else begin
              mem[wr_addr_reg] <= mac_byte;
              wr_addr_reg      <= wr_next;
              byte_count_reg   <= byte_count_reg + 16'h0001;
            end
          end else if (mac_end) begin
            header_reg  <= {status_vec, 3'h0, next_pkt};
            hdr_idx_reg <= 3'h0;
            state_reg   <= ST_HDR;
          end
        end
        ST_HDR: begin
          // next pointer low, high, then status vector low byte first
          mem[hdr_addr_reg] <= header_reg[7:0];
          header_reg        <= {8'h00, header_reg[47:8]};
          hdr_addr_reg      <= hdr_next;
          hdr_idx_reg       <= hdr_idx_reg + 3'h1;
          if (hdr_idx_reg == `RXBSM_HDR_BYTES - 3'h1) begin
            rx_hw_write_pointer_reg  <= next_pkt;
            pending_packet_count_reg <= pending_packet_count_reg + 8'h01;
            packet_pending_flag      <= 1'b1;
            carrier_seen_reg         <= mac_carrier_evt;
            longdrop_seen_reg        <= mac_long_evt || mac_drop_evt;
            state_reg                <= ST_IDLE;
          end
        end
        ST_SKIP: begin
          if (mac_end) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      // a decrement in the completion cycle cancels against the increment
      if (dec_req && pending_packet_count_reg != 8'h00) begin
        if (state_reg == ST_HDR && hdr_idx_reg == `RXBSM_HDR_BYTES - 3'h1) begin
          pending_packet_count_reg <= pending_packet_count_reg;
          packet_pending_flag      <= 1'b1;
        end else begin
          pending_packet_count_reg <= pending_packet_count_reg - 8'h01;
          packet_pending_flag      <= (pending_packet_count_reg != 8'h01);
        end
      end
      // flag clear by writing one; a same-cycle set still wins
      if (wr_go && wr_lane && wa == `RXBSM_ADDR_FLAGS && wd[`RXBSM_BIT_RXERR]
          && !(state_reg == ST_IDLE && mac_start
               && pending_packet_count_reg == `RXBSM_CNT_MAX)
          && !(state_reg == ST_DATA && mac_byte_valid && wr_blocked)) begin
        rx_error_flag <= 1'b0;
      end
    end
  end

  // register writes
  always @(posedge clock) begin
    if (reset) begin
      s_axi_awready                  <= 1'b0;
      s_axi_wready                   <= 1'b0;
      s_axi_bvalid                   <= 1'b0;
      s_axi_bresp                    <= 2'b00;
      aw_hold_reg                    <= 1'b0;
      w_hold_reg                     <= 1'b0;
      aw_addr_reg                    <= 8'h00;
      w_data_reg                     <= 32'h0;
      w_strb_reg                     <= 4'h0;
      rx_buffer_start_reg            <= `RXBSM_RST_RXSTART;
      rx_buffer_end_reg              <= `RXBSM_RST_RXEND;
      rx_release_pointer_reg         <= `RXBSM_RST_RXSTART;
      rx_release_low_hold_reg        <= 8'h00;
      read_auto_increment_enable_reg <= CTRL2_RST[`RXBSM_BIT_READ_AUTO_INCREMENT_ENABLE];
    end else begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        if (wa == `RXBSM_ADDR_CTRL2) begin
          if (wr_lane) begin
            read_auto_increment_enable_reg <= wd[`RXBSM_BIT_READ_AUTO_INCREMENT_ENABLE];
          end
        end else if (wa == `RXBSM_ADDR_RELPTR_LO) begin
          if (wr_lane) begin
            rx_release_low_hold_reg <= wd[7:0];
          end
        end else if (wa == `RXBSM_ADDR_RELPTR_HI) begin
          if (wr_lane) begin
            rx_release_pointer_reg <= {wd[4:0], rx_release_low_hold_reg};
          end
        end else if (wa == `RXBSM_ADDR_RXSTART) begin
          if (wr_lane) begin
            rx_buffer_start_reg[7:0] <= wd[7:0];
          end
          if (ws[1]) begin
            rx_buffer_start_reg[12:8] <= wd[12:8];
          end
        end else if (wa == `RXBSM_ADDR_RXEND) begin
          if (wr_lane) begin
            rx_buffer_end_reg[7:0] <= wd[7:0];
          end
          if (ws[1]) begin
            rx_buffer_end_reg[12:8] <= wd[12:8];
          end
        end else if (wa == `RXBSM_ADDR_RDPTR || wa == `RXBSM_ADDR_FLAGS) begin
          s_axi_bresp <= 2'b00;
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end
    end
  end

  // register reads and buffer read pointer
  always @(posedge clock) begin
    if (reset) begin
      s_axi_arready           <= 1'b0;
      s_axi_rvalid            <= 1'b0;
      s_axi_rdata             <= 32'h0;
      s_axi_rresp             <= 2'b00;
      buffer_read_pointer_reg <= `RXBSM_RST_RXSTART;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (wr_go && wa == `RXBSM_ADDR_RDPTR) begin
        if (wr_lane) begin
          buffer_read_pointer_reg[7:0] <= wd[7:0];
        end
        if (ws[1]) begin
          buffer_read_pointer_reg[12:8] <= wd[12:8];
        end
      end else if (rd_data && read_auto_increment_enable_reg) begin
        buffer_read_pointer_reg <= rd_next;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        s_axi_rdata  <= 32'h0;
        if (s_axi_araddr == `RXBSM_ADDR_CTRL2) begin
          s_axi_rdata[`RXBSM_BIT_READ_AUTO_INCREMENT_ENABLE] <= read_auto_increment_enable_reg;
        end else if (s_axi_araddr == `RXBSM_ADDR_RELPTR_LO) begin
          s_axi_rdata[7:0] <= rx_release_pointer_reg[7:0];
        end else if (s_axi_araddr == `RXBSM_ADDR_RELPTR_HI) begin
          s_axi_rdata[4:0] <= rx_release_pointer_reg[12:8];
        end else if (s_axi_araddr == `RXBSM_ADDR_RXSTART) begin
          s_axi_rdata[12:0] <= rx_buffer_start_reg;
        end else if (s_axi_araddr == `RXBSM_ADDR_RXEND) begin
          s_axi_rdata[12:0] <= rx_buffer_end_reg;
        end else if (s_axi_araddr == `RXBSM_ADDR_RDPTR) begin
          s_axi_rdata[12:0] <= buffer_read_pointer_reg;
        end else if (s_axi_araddr == `RXBSM_ADDR_WRPTR) begin
          s_axi_rdata[12:0] <= rx_hw_write_pointer_reg;
        end else if (s_axi_araddr == `RXBSM_ADDR_PKTCNT) begin
          s_axi_rdata[7:0] <= pending_packet_count_reg;
        end else if (s_axi_araddr == `RXBSM_ADDR_FLAGS) begin
          s_axi_rdata[`RXBSM_BIT_PKTPEND] <= packet_pending_flag;
          s_axi_rdata[`RXBSM_BIT_RXERR]   <= rx_error_flag;
        end else if (s_axi_araddr == `RXBSM_ADDR_RDDATA) begin
          s_axi_rdata[7:0] <= mem[buffer_read_pointer_reg];
        end else begin
          s_axi_rresp <= 2'b10;
        end
      end
    end
  end
endmodule

//--- rxbsm_chk.sv
// port assertions for the receive buffer status manager
// assumes one clock domain with a synchronous active high reset
`timescale 1ns/100ps
module rxbsm_chk (
  input wire        clock,
  input wire        reset,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        mac_start,
  input wire        mac_end,
  input wire        rx_busy,
  input wire        rx_error_flag,
  input wire        packet_pending_flag
);
  // cycles since the last frame end, saturating so old frames stop counting
  reg [3:0] since_end;
  always @(posedge clock) begin
    if (reset)
      since_end <= 4'hF;
    else if (mac_end)
      since_end <= 4'h0;
    else if (since_end != 4'hF)
      since_end <= since_end + 4'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_aw_taken; s_axi_awvalid && s_axi_awready; endsequence
  sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
  property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
  property p_w_answer; s_aw_taken |-> ##[1:4] s_axi_bvalid; endproperty
  a_w_answer: assert property (p_w_answer) else $error("no write response");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_r_answer; s_ar_taken |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data unstable");
  property p_pend_rise; $rose(packet_pending_flag) |-> since_end inside {[3:9]}; endproperty
  a_pend_rise: assert property (p_pend_rise) else $error("pending without frame");
  property p_pend_fall; $fell(packet_pending_flag) |-> ##[0:3] s_axi_bvalid; endproperty
  a_pend_fall: assert property (p_pend_fall) else $error("pending cleared alone");
  property p_err_fall; $fell(rx_error_flag) |-> ##[0:3] s_axi_bvalid; endproperty
  a_err_fall: assert property (p_err_fall) else $error("error flag not sticky");
  property p_err_rise;
    $rose(rx_error_flag) |-> $past(rx_busy) || $past(mac_start) || $past(mac_end)
      || since_end <= 4'h9;
  endproperty
  a_err_rise: assert property (p_err_rise) else $error("error without frame");
  property p_busy_end; rx_busy && mac_end |-> ##[1:8] !rx_busy; endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy stuck");
endmodule
bind rxbsm_top rxbsm_chk u_rxbsm_chk (.*);

//--- rxbsm_mac_model.sv
// partner model of the mac receive side feeding frame bytes
// assumes the manager's clock; flag levels are only trusted at the end pulse
`timescale 1ns/100ps
module rxbsm_mac_model (
  input  wire        clock,
  output reg         mac_start = 1'b0,
  output reg         mac_byte_valid = 1'b0,
  output reg  [7:0]  mac_byte = 8'h00,
  output reg         mac_end = 1'b0,
  output reg  [2:0]  mac_extra_bits = 3'h0,
  output wire        mac_vlan,
  output wire        mac_unknown_op,
  output wire        mac_pause_ok,
  output wire        mac_ctrl_frame,
  output wire        mac_bcast,
  output wire        mac_mcast,
  output wire        mac_crc_bad,
  output wire        mac_symbol_err,
  output reg  [15:0] mac_type_len = 16'h0000,
  output reg         mac_carrier_evt = 1'b0,
  output reg         mac_long_evt = 1'b0,
  output reg         mac_drop_evt = 1'b0
);
  reg [7:0] lv = 8'h00;
  assign {mac_vlan, mac_unknown_op, mac_pause_ok, mac_ctrl_frame, mac_bcast, mac_mcast,
          mac_crc_bad, mac_symbol_err} = lv;
  task frame(input [7:0] n, input [15:0] tl, input [2:0] xb, input [10:0] f);
    integer i;
    begin
      @(posedge clock);
      {mac_carrier_evt, mac_long_evt, mac_drop_evt} <= f[2:0];
      @(posedge clock);
      {mac_carrier_evt, mac_long_evt, mac_drop_evt} <= 3'h0;
      mac_start <= 1'b1;
      @(posedge clock);
      mac_start <= 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        mac_byte_valid <= 1'b1;
        mac_byte <= n + i[7:0];
        @(posedge clock);
        mac_byte_valid <= 1'b0;
        mac_byte <= ~mac_byte;
        @(posedge clock);
      end
      mac_end <= 1'b1;
      lv <= f[10:3];
      mac_extra_bits <= xb;
      mac_type_len <= tl;
      @(posedge clock);
      // flags flip after the end pulse so a late sample is caught
      mac_end <= 1'b0;
      lv <= ~f[10:3];
      mac_extra_bits <= ~xb;
      mac_type_len <= ~tl;
      repeat (8) @(posedge clock);
    end
  endtask
endmodule

//--- rxbsm_top_bench.sv
// self-checking bench for the receive buffer status manager
// assumes an axi4-lite master built from tasks and the mac partner model
`timescale 1ns/100ps
`include "rxbsm_consts.vh"
module rxbsm_top_bench;
  reg         clock = 1'b0, reset = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  reg         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        mac_start, mac_byte_valid, mac_end, mac_vlan, mac_ctrl_frame, mac_pause_ok;
  wire        mac_unknown_op, mac_bcast, mac_mcast, mac_crc_bad, mac_symbol_err;
  wire        mac_carrier_evt, mac_long_evt, mac_drop_evt, rx_busy, rx_error_flag;
  wire        packet_pending_flag;
  wire [7:0]  mac_byte;
  wire [2:0]  mac_extra_bits;
  wire [15:0] mac_type_len;
  integer     err_total = 0, comparisons = 0, i, p, k, j;
  reg  [12:0] wp, nx;
  reg  [53:0] t, ft [0:3];
  always #5 clock = ~clock;
  rxbsm_top u_rxbsm_top (.*);
  rxbsm_mac_model u_rxbsm_mac_model (.*);
  task chk(input [63:0] nm, input [31:0] s, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("BAD %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg ad, dd;
    begin
      @(posedge clock);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_bready <= 1'b1;
      ad = 1'b0;
      dd = 1'b0;
      while (!(ad && dd)) begin
        @(posedge clock);
        if (s_axi_awready) ad = 1'b1;
        if (s_axi_wready) dd = 1'b1;
        if (ad) s_axi_awvalid <= 1'b0;
        if (dd) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid) @(posedge clock);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    begin
      @(posedge clock);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      do @(posedge clock); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clock); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      chk("rdata", s_axi_rdata, e);
    end
  endtask
  task relset(input [12:0] v);
    begin
      wr(`RXBSM_ADDR_RELPTR_LO, {19'h0, v}, 2'b00);
      wr(`RXBSM_ADDR_RELPTR_HI, {27'h0, v[12:8]}, 2'b00);
    end
  endtask
  task hdr;
    begin
      wr(`RXBSM_ADDR_RDPTR, {19'h0, wp}, 2'b00);
      rd(`RXBSM_ADDR_RDDATA, {24'h0, nx[7:0]}, 2'b00);
      rd(`RXBSM_ADDR_RDDATA, {27'h0, nx[12:8]}, 2'b00);
      rd(`RXBSM_ADDR_RDDATA, {24'h0, t[53:46]}, 2'b00);
      rd(`RXBSM_ADDR_RDDATA, 32'h0, 2'b00);
      rd(`RXBSM_ADDR_RDDATA, {24'h0, t[15:8]}, 2'b00);
      rd(`RXBSM_ADDR_RDDATA, {24'h0, t[7:0]}, 2'b00);
      for (i = 0; i < t[53:46]; i = i + 1)
        rd(`RXBSM_ADDR_RDDATA, {24'h0, t[53:46] + i[7:0]}, 2'b00);
    end
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    // length, type/length, extra bits, flags, status bytes two and three
    ft[0] = {8'h14, 16'h8808, 3'h0, 11'h5C0, 8'hC0, 8'h5A};
    ft[1] = {8'h15, 16'h8808, 3'h3, 11'h2A0, 8'hC0, 8'h2D};
    ft[2] = {8'h15, 16'h0010, 3'h0, 11'h016, 8'h35, 8'h00};
    ft[3] = {8'h1C, 16'h000A, 3'h0, 11'h009, 8'h01, 8'h00};
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rd(`RXBSM_ADDR_CTRL2, 32'h80, 2'b00);
    rd(`RXBSM_ADDR_RXEND, 32'h1FFF, 2'b00);
    rd(`RXBSM_ADDR_PKTCNT, 32'h0, 2'b00);
    rd(8'h30, 32'h0, 2'b10);
    wr(8'h30, 32'h1, 2'b10);
    wr(`RXBSM_ADDR_RELPTR_LO, 32'h3F, 2'b00);
    rd(`RXBSM_ADDR_RELPTR_LO, 32'h0, 2'b00);
    wr(`RXBSM_ADDR_RELPTR_HI, 32'h0, 2'b00);
    rd(`RXBSM_ADDR_RELPTR_LO, 32'h3F, 2'b00);
    wr(`RXBSM_ADDR_RXEND, 32'h3F, 2'b00);
    $display("test registers done");
    wp = 13'h0;
    for (p = 0; p < 2; p = p + 1) begin
      for (k = 0; k < 2; k = k + 1)
        u_rxbsm_mac_model.frame(ft[2*p+k][53:46], ft[2*p+k][45:30], ft[2*p+k][29:27],
                                ft[2*p+k][26:16]);
      rd(`RXBSM_ADDR_PKTCNT, 32'h2, 2'b00);
      chk("pending", {31'h0, packet_pending_flag}, 32'h1);
      for (k = 0; k < 2; k = k + 1) begin
        t = ft[2*p+k];
        nx = wp + 13'd6 + t[53:46] + t[46];
        if (nx > 13'd63) nx = nx - 13'd64;
        hdr;
        relset(nx - 13'd1);
        wr(`RXBSM_ADDR_CTRL2, 32'hC0, 2'b00);
        rd(`RXBSM_ADDR_PKTCNT, (k == 0) ? 32'h1 : 32'h0, 2'b00);
        chk("pending", {31'h0, packet_pending_flag}, (k == 0) ? 32'h1 : 32'h0);
        wp = nx;
      end
    end
    rd(`RXBSM_ADDR_WRPTR, {19'h0, wp}, 2'b00);
    wr(`RXBSM_ADDR_CTRL2, 32'hC0, 2'b00);
    rd(`RXBSM_ADDR_PKTCNT, 32'h0, 2'b00);
    $display("test frames done");
    u_rxbsm_mac_model.frame(8'h3C, 16'h0800, 3'h0, 11'h000);
    chk("rx_err", {31'h0, rx_error_flag}, 32'h1);
    rd(`RXBSM_ADDR_FLAGS, 32'h1, 2'b00);
    rd(`RXBSM_ADDR_PKTCNT, 32'h0, 2'b00);
    rd(`RXBSM_ADDR_WRPTR, {19'h0, wp}, 2'b00);
    wr(`RXBSM_ADDR_FLAGS, 32'h1, 2'b00);
    chk("rx_err", {31'h0, rx_error_flag}, 32'h0);
    $display("test overflow done");
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    relset(13'h1FFF);
    for (j = 0; j < 255; j = j + 1)
      u_rxbsm_mac_model.frame(8'h02, 16'h0800, 3'h0, 11'h000);
    rd(`RXBSM_ADDR_PKTCNT, 32'hFF, 2'b00);
    u_rxbsm_mac_model.frame(8'h02, 16'h0800, 3'h0, 11'h000);
    chk("rx_err", {31'h0, rx_error_flag}, 32'h1);
    rd(`RXBSM_ADDR_PKTCNT, 32'hFF, 2'b00);
    rd(`RXBSM_ADDR_WRPTR, 32'h7F8, 2'b00);
    wr(`RXBSM_ADDR_CTRL2, 32'hC0, 2'b00);
    rd(`RXBSM_ADDR_PKTCNT, 32'hFE, 2'b00);
    chk("pending", {31'h0, packet_pending_flag}, 32'h1);
    $display("test count limit done");
    end_of_test;
  end
  initial begin
    repeat (60000) @(posedge clock);
    err_total = err_total + 1;
    end_of_test;
  end
endmodule
